//--- logic/pce_core.sv
// Staging register and bit-serial accumulator.
// Assumes one load at a time; loads while busy are dropped.
`timescale 1ns/1ps
`default_nettype none
module pce_core
    import pce_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Async reset, high
    pce_cfg_if.core cfg // Configuration and state
);
    pce_state_t state_r;
    logic [15:0] shift_r;
    logic [15:0] acc_r;
    logic [3:0] cnt_r;
    logic [15:0] amask;
    logic [15:0] dmask;
    logic [15:0] poly;
    logic in_bit;
    logic fb;
    logic [15:0] acc_nxt;

    pce_mask u_amask (.len(cfg.poly_length_field), .mask(amask));
    pce_mask u_dmask (.len(cfg.data_length_field), .mask(dmask));

    // ****************************************
    // Polynomial and feedback
    // ****************************************
    always_comb begin
        poly = (cfg.poly_term_regs | 16'h0001) & amask;
        in_bit = cfg.bit_order_select ? shift_r[0]
                                      : shift_r[cfg.data_length_field];
        fb = in_bit ^ acc_r[cfg.poly_length_field];
        acc_nxt = {acc_r[14:0], 1'b0} & amask;
        if (fb) begin
            acc_nxt = acc_nxt ^ poly;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= PCE_IDLE;
            cnt_r <= PCE_CNT_ZERO;
        end else begin
            case (state_r)
                PCE_IDLE: begin
                    if (cfg.load) begin
                        state_r <= PCE_SHIFT;
                        cnt_r <= cfg.data_length_field;
                    end
                end
                PCE_SHIFT: begin
                    if (cnt_r == PCE_CNT_ZERO) begin
                        state_r <= PCE_IDLE;
                    end
                    cnt_r <= cnt_r - 4'h1;
                end
                default: state_r <= PCE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_r <= PCE_ZERO16;
        end else if (state_r == PCE_IDLE && cfg.load) begin
            shift_r <= cfg.word & dmask;
        end else if (state_r == PCE_SHIFT) begin
            shift_r <= cfg.bit_order_select ? {1'b0, shift_r[15:1]} : {shift_r[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= PCE_ZERO16;
        end else if (cfg.seed_we && state_r == PCE_IDLE) begin
            acc_r <= cfg.seed & amask;
        end else if (state_r == PCE_SHIFT) begin
            acc_r <= acc_nxt;
        end else begin
            // Drop bits above a shrunk width
            acc_r <= acc_r & amask;
        end
    end

    assign cfg.busy = (state_r == PCE_SHIFT);
    assign cfg.check_accumulator = acc_r;
    assign cfg.staging_shift_reg = shift_r;

    a_shift_len: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == PCE_IDLE && cfg.load && cfg.data_length_field == 4'h7)
        |=> cfg.busy [*8] ##1 !cfg.busy) else $error("Shift length wrong");
    a_acc_width: assert property (@(posedge clk) disable iff (sys_rst)
        (acc_r & ~amask) == PCE_ZERO16 || $changed(cfg.poly_length_field))
        else $error("Accumulator above width");
    a_seed_take: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg.seed_we && !cfg.busy) |=> acc_r == ($past(cfg.seed) & $past(amask)))
        else $error("Seed not taken");
    a_load_mask: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg.load && !cfg.busy) |=> shift_r == ($past(cfg.word) & $past(dmask)))
        else $error("Staging load wrong");
    a_poly_ends: assert property (@(posedge clk) disable iff (sys_rst)
        poly[0] == 1'b1) else $error("Low term not forced");
    a_fb_xor: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg.busy && fb && !cfg.seed_we) |=> acc_r[0] == 1'b1)
        else $error("Feedback xor missing");
    a_msb_first: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg.busy && !cfg.bit_order_select) |=> shift_r == {$past(shift_r[14:0]), 1'b0})
        else $error("MSb order wrong");
    a_lsb_first: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg.busy && cfg.bit_order_select) |=> shift_r[15] == 1'b0)
        else $error("LSb shift wrong");
endmodule : pce_core
`default_nettype wire

//--- logic/pce_mask.sv
// Width mask generator: ones in bits 0..len.
// Assumes pure combinational use.
`timescale 1ns/1ps
`default_nettype none
module pce_mask
    import pce_pkg::*;
(
    input wire logic [3:0] len, // Length minus one
    output logic [15:0] mask // Ones up to len
);
    genvar i;
    generate
        for (i = 0; i < PCE_W; i++) begin : g_m
            assign mask[i] = (i <= int'(len));
        end
    endgenerate
endmodule : pce_mask
`default_nettype wire

//--- logic/pce_top.sv
// AHB-Lite register block of the programmable check engine.
// Assumes single word transfers and one slave; scanner words come in by valid/ready.
`timescale 1ns/1ps
`default_nettype none
module pce_top
    import pce_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Async reset, high
    input wire logic hsel, // Slave select
    input wire logic [7:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data
    input wire logic [15:0] scan_word, // Scanner word
    input wire logic scan_valid, // Scanner word valid
    output logic scan_ready // Engine takes scanner word
);
    pce_cfg_if cfg ();

    logic [PCE_CTRL_W-1:0] ctrl_r;
    logic [15:0] poly_r;
    logic [7:0] dlo_r;
    logic [7:0] dhi_r;
    logic wr_ph_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_nxt;
    logic take;
    logic src_scan;
    logic enable;
    logic lo_wr;
    logic acc_wr;

    // ****************************************
    // Bus address phase
    // ****************************************
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ph_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_ph_r <= take && hwrite;
            addr_r <= take ? haddr : addr_r;
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (haddr)
            PCE_OFS_CTRL: rd_nxt = {21'h0, cfg.busy, ctrl_r[PCE_EN_BIT-1:0]};
            PCE_OFS_POLY: rd_nxt = {16'h0000, poly_r[15:1], 1'b0};
            PCE_OFS_DATA_LO: rd_nxt = {24'h000000, dlo_r};
            PCE_OFS_DATA_HI: rd_nxt = {24'h000000, dhi_r};
            PCE_OFS_ACC: rd_nxt = {16'h0000, cfg.check_accumulator};
            PCE_OFS_STAT: rd_nxt = {31'h0, cfg.busy};
            PCE_OFS_SHIFT: rd_nxt = {16'h0000, cfg.staging_shift_reg};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata_r <= rd_nxt;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    assign lo_wr = wr_ph_r && addr_r == PCE_OFS_DATA_LO;
    assign acc_wr = wr_ph_r && addr_r == PCE_OFS_ACC;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= {3'h0, PCE_LEN_RST, PCE_LEN_RST};
            poly_r <= PCE_ZERO16;
            dlo_r <= 8'h00;
            dhi_r <= 8'h00;
        end else if (wr_ph_r) begin
            case (addr_r)
                PCE_OFS_CTRL: ctrl_r <= hwdata[PCE_CTRL_W-1:0];
                PCE_OFS_POLY: poly_r <= {hwdata[15:1], 1'b0};
                PCE_OFS_DATA_LO: dlo_r <= hwdata[7:0];
                PCE_OFS_DATA_HI: dhi_r <= hwdata[7:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // ****************************************
    // Source select and core link
    // ****************************************
    assign src_scan = ctrl_r[PCE_SRC_BIT];
    assign enable = ctrl_r[PCE_EN_BIT];
    assign scan_ready = enable && src_scan && !cfg.busy && !acc_wr;

    assign cfg.poly_length_field = ctrl_r[PCE_POLY_LEN_LSB+3:PCE_POLY_LEN_LSB];
    assign cfg.data_length_field = ctrl_r[PCE_DATA_LEN_LSB+3:PCE_DATA_LEN_LSB];
    assign cfg.bit_order_select = ctrl_r[PCE_ORDER_BIT];
    assign cfg.poly_term_regs = poly_r;
    assign cfg.word = src_scan ? scan_word : {dhi_r, hwdata[7:0]};
    assign cfg.load = enable && (src_scan ? (scan_valid && scan_ready)
                                          : lo_wr);
    assign cfg.seed_we = acc_wr;
    assign cfg.seed = hwdata[15:0];

    pce_core u_core (.clk(clk), .sys_rst(sys_rst), .cfg(cfg));

    a_lo_triggers: assert property (@(posedge clk) disable iff (sys_rst)
        (lo_wr && enable && !src_scan && !cfg.busy) |=> cfg.busy)
        else $error("Low write did not start");
    a_poly_lsb: assert property (@(posedge clk) disable iff (sys_rst)
        poly_r[0] == 1'b0) else $error("Poly low bit stored");
endmodule : pce_top
`default_nettype wire

//--- shared/pce_cfg_if.sv
// Configuration carrier from the register block to the shift core.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface pce_cfg_if;
    import pce_pkg::*;
    logic [3:0] poly_length_field;
    logic [3:0] data_length_field;
    logic bit_order_select;
    logic [15:0] poly_term_regs;
    logic [15:0] word;
    logic load;
    logic seed_we;
    logic [15:0] seed;
    logic busy;
    logic [15:0] check_accumulator;
    logic [15:0] staging_shift_reg;
    modport regs (output poly_length_field, data_length_field, bit_order_select,
                  poly_term_regs, word, load, seed_we, seed,
                  input busy, check_accumulator, staging_shift_reg);
    modport core (input poly_length_field, data_length_field, bit_order_select,
                  poly_term_regs, word, load, seed_we, seed,
                  output busy, check_accumulator, staging_shift_reg);
endinterface : pce_cfg_if
`default_nettype wire

//--- shared/pce_pkg.sv
// Constants, offsets and types of the programmable check engine.
// Assumes a 32-bit AHB-Lite register bus and one 40 MHz clock.
// Overview of operation
// - Length field n-1 gives n-bit accumulator.
// - Top and bottom polynomial terms forced one.
// - Middle terms come from polynomial term registers.
// - Low term bit reads zero, acts one.
// - Data bits above data length ignored.
// - Word staged in shift register, then accumulated.
// - Order bit clear: shift MSb first.
// - Order bit set: shift LSb first.
// - Accumulator writable as seed value.
// - Low data write latches staging register.
// - Data from registers or memory scanner.
package pce_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] PCE_OFS_CTRL = 8'h00;
    localparam logic [7:0] PCE_OFS_POLY = 8'h04;
    localparam logic [7:0] PCE_OFS_DATA_LO = 8'h08;
    localparam logic [7:0] PCE_OFS_DATA_HI = 8'h0c;
    localparam logic [7:0] PCE_OFS_ACC = 8'h10;
    localparam logic [7:0] PCE_OFS_STAT = 8'h14;
    localparam logic [7:0] PCE_OFS_SHIFT = 8'h18;
    // ****************************************
    // Control field layout
    // ****************************************
    localparam int PCE_POLY_LEN_LSB = 0;
    localparam int PCE_DATA_LEN_LSB = 4;
    localparam int PCE_ORDER_BIT = 8;
    localparam int PCE_SRC_BIT = 9;
    localparam int PCE_EN_BIT = 10;
    localparam int PCE_CTRL_W = 11;
    localparam int PCE_BYTE_W = 8;
    localparam int PCE_W = 16;
    localparam logic [3:0] PCE_LEN_RST = 4'hf;
    localparam logic [15:0] PCE_ZERO16 = 16'h0000;
    localparam logic [3:0] PCE_CNT_ZERO = 4'h0;
    typedef enum logic [1:0] {PCE_IDLE, PCE_SHIFT} pce_state_t;
endpackage : pce_pkg

//--- verif/pce_scan_model.sv
// Stand-in for the program memory scanner feeding words by valid/ready.
// Assumes the engine takes a word at an edge where valid and ready are high.
`timescale 1ns/1ps
`default_nettype none
module pce_scan_model (
    input wire logic clk, // System clock
    output logic [15:0] scan_word, // Word offered
    output logic scan_valid, // Word offered when high
    input wire logic scan_ready // Engine takes word
);
    initial begin
        scan_word = 16'h0000;
        scan_valid = 1'b0;
    end

    // Offer one word after a gap, hold it until taken or for at most 100 edges, then scramble the lines
    task automatic send(input logic [15:0] w, input int gap);
        int i;
        repeat (gap) @(posedge clk);
        scan_word <= w;
        scan_valid <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (scan_ready === 1'b1) break;
        end
        scan_valid <= 1'b0;
        scan_word <= ~w;
    endtask : send
endmodule : pce_scan_model
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench of the check engine over AHB-Lite.
// Assumes the scanner stand-in pce_scan_model and one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top import pce_pkg::*;;
    typedef struct {logic [31:0] v; string n;} pce_note_t;
    logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, scan_valid, scan_ready, sc, ph;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, d, lo, hi;
    logic [15:0] scan_word, p, s, w, m, e;
    logic [3:0] pl, dl;
    int num_errors, n_tests, cyc, seed, k;
    pce_note_t q[$];
    pce_note_t nt;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    assign hready = hreadyout;

    pce_top dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scan_word(scan_word),
        .scan_valid(scan_valid), .scan_ready(scan_ready));
    pce_scan_model scan_u (.clk(clk), .scan_word(scan_word), .scan_valid(scan_valid),
        .scan_ready(scan_ready));

    // ****************************************
    // Bus tasks and reference model
    // ****************************************
    task automatic bus(input logic [7:0] a, input logic wt, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wt;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(a, 1'b1, v, d);
    endtask : wr

    // Note the expectation off the edge so the watcher never pops it early
    task automatic chk(input logic [7:0] a, input logic [31:0] ev, input string n);
        @(negedge clk);
        q.push_back('{ev, n});
        bus(a, 1'b0, 32'h0, d);
    endtask : chk

    task automatic wait_idle;
        int i;
        for (i = 0; i < 40; i++) begin
            bus(PCE_OFS_STAT, 1'b0, 32'h0, d);
            if (d[0] === 1'b0) break;
        end
    endtask : wait_idle

    function automatic logic [15:0] crc(logic [15:0] a, logic [15:0] pt, logic [15:0] wd,
                                        logic [3:0] pn, logic [3:0] dn, logic o);
        logic [15:0] mk;
        logic b;
        int i;
        mk = 16'hffff >> (4'hf - pn);
        a = a & mk;
        for (i = 0; i <= dn; i++) begin
            b = o ? wd[i] : wd[dn - i];
            a = (a[pn] ^ b) ? (((a << 1) ^ (pt | 16'h0001)) & mk) : ((a << 1) & mk);
        end
        return a;
    endfunction : crc

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    // Watcher: compare each queued read at its data-phase edge
    always @(posedge clk) begin
        if (ph && q.size() > 0) begin
            nt = q.pop_front();
            n_tests++;
            if (hrdata !== nt.v) begin
                num_errors++;
                $display("mismatch %s expected %h seen %h", nt.n, nt.v, hrdata);
            end
            if (hresp !== 1'b0) begin
                num_errors++;
                $display("mismatch hresp expected 0 seen %b", hresp);
            end
        end
        ph = hsel && htrans[1] && !hwrite && hready;
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, ph, cyc} = '0;
        hsize = 3'h2;
        sys_rst = 1'b1;
        seed = 32'h2ef5;
        num_errors = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        chk(PCE_OFS_CTRL, 32'h0ff, "ctrl reset");
        chk(PCE_OFS_ACC, 32'h0, "acc reset");
        wr(PCE_OFS_POLY, 32'hffff);
        chk(PCE_OFS_POLY, 32'hfffe, "poly low term");
        chk(8'h1c, 32'h0, "unmapped");
        $display("test registers done");
        for (k = 0; k < 8; k++) begin
            pl = (k < 2) ? 4'hf : 4'($random(seed));
            dl = (k == 2) ? 4'h0 : (k == 3) ? 4'h7 : (k < 2) ? 4'hf : 4'($random(seed));
            sc = k > 5;
            p = 16'($random(seed));
            s = 16'($random(seed));
            lo = $random(seed);
            hi = $random(seed);
            m = 16'hffff >> (4'hf - dl);
            wr(PCE_OFS_CTRL, {21'h0, 1'b1, sc, k[0], dl, pl});
            wr(PCE_OFS_POLY, {16'h0, p});
            wr(PCE_OFS_ACC, {16'h0, s});
            if (sc) begin
                w = lo[15:0];
                scan_u.send(w, k);
            end else begin
                wr(PCE_OFS_DATA_HI, hi);
                wr(PCE_OFS_DATA_LO, lo);
                w = {hi[7:0], lo[7:0]};
            end
            wait_idle();
            e = crc(s, p, w & m, pl, dl, k[0]);
            chk(PCE_OFS_ACC, {16'h0, e}, "accumulator");
            $display("test crc %0d done", k);
        end
        summarize();
    end
endmodule : tb_top
`default_nettype wire
